/* common/safety_words_defines.svh */
// bit positions and reset values of the safety command and state words
// assumes 16-bit words, byte 0 in bits 7:0 and byte 1 in bits 15:8
`ifndef SAFETY_WORDS_DEFINES_SVH
`define SAFETY_WORDS_DEFINES_SVH

`define CMD_TORQUE_OFF_BIT   0
`define CMD_STOP_BIT         1
`define CMD_LIMSPEED_BIT     4
`define CMD_EVENT_ACK_BIT    7
`define CMD_LEVEL_LO_BIT     9
`define CMD_LEVEL_HI_BIT     10
`define CMD_DIR_POS_BIT      12
`define CMD_DIR_NEG_BIT      13

`define STA_TORQUE_OFF_BIT   0
`define STA_STOP_BIT         1
`define STA_LIMSPEED_BIT     4
`define STA_EVENT_BIT        7
`define STA_LEVEL_LO_BIT     9
`define STA_LEVEL_HI_BIT     10
`define STA_DIR_POS_BIT      12
`define STA_DIR_NEG_BIT      13
`define STA_SPEED_MON_BIT    15

`define INPUT_STATE_LSB      8
`define NUM_SAFE_INPUTS      3

// all selects inactive (ones) after reset, ack line idle low
`define CMD_A_RESET          16'h3617
`define WORD_ZERO            16'h0000

`endif

/* common/safety_words_pkg.sv */
// types shared by the safety word block
// assumes the defines header sits in the include path
package safety_words_pkg;

  typedef struct packed {
    logic       torque_off;
    logic       controlled_stop;
    logic       limited_speed;
    logic [1:0] speed_level;
    logic       dir_pos;
    logic       dir_neg;
  } func_sel_t;

  typedef struct packed {
    logic [2:0] level;
    logic [2:0] in_use;
    logic [2:0] disabled;
  } safe_inputs_t;

endpackage

/* dv/safety_control_status_words_tb.sv */
// testbench: command words go through the partner model, state words are compared
// assumes state word a answers two edges after the last load, input word one edge
`timescale 1ns/1ps
`default_nettype none
module safety_control_status_words_tb;
  import safety_words_pkg::*;
  logic         core_clk, rst_n, clk_en, cmd_valid, event_raise, spd, ack_pulse;
  logic [15:0]  cmd_a, cmd_b, state_a, state_in;
  safe_inputs_t safe_in;
  func_sel_t    func_active;
  int           fail_count = 0, compares = 0, cycles = 0;
  logic [15:0]  words [5] = '{16'hFFFF, 16'h0000, 16'hC96C, 16'h3292, 16'hFDEE};
  safety_controller_model i_ctrl (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_a(cmd_a), .cmd_b(cmd_b));
  safety_control_status_words i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .safety_command_word_a(cmd_a), .safety_command_word_b(cmd_b), .event_raise(event_raise),
    .speed_below_limit(spd), .safe_inputs(safe_in), .safety_state_word_a(state_a),
    .safety_input_state_word(state_in), .event_ack_pulse(ack_pulse), .func_active(func_active));
  // =====
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count = fail_count + 1;
      end_sim();
    end
  end
  // =====
  // helpers
  function automatic logic [15:0] exp_a(input logic [15:0] c, input logic s, input logic e);
    exp_a = {s, 1'b0, ~c[13], ~c[12], 1'b0, c[10:9], 1'b0, e, 2'b00, ~c[4], 2'b00, ~c[1], ~c[0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // =====
  // scenarios
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    event_raise = 1'b0;
    spd = 1'b1;
    safe_in = '0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(2);
    chk(state_in, 16'h0000);
    chk({15'h0, ack_pulse}, 16'h0000);
    // selects, level coding, direction and speed bits; ignored bits set in some words
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      spd <= i[0];
      i_ctrl.send_pair(words[i], words[i]);
      tick(2);
      chk(state_a, exp_a(words[i], i[0], 1'b0));
      chk({9'h0, func_active}, {9'h0, ~words[i][0], ~words[i][1], ~words[i][4], words[i][10:9],
        ~words[i][12], ~words[i][13]});
    end
    // clock enable low: a load must not land
    @(posedge core_clk);
    clk_en <= 1'b0;
    i_ctrl.send_pair(16'h3606, 16'h3606);
    tick(2);
    chk(state_a, exp_a(words[4], 1'b0, 1'b0));
    clk_en <= 1'b1;
    tick(2);
    chk(state_a, exp_a(words[4], 1'b0, 1'b0));
    // event: sticky, steady zero does not clear, falling ack clears with one pulse
    i_ctrl.send_pair(16'h3617, 16'h3617);
    @(posedge core_clk);
    spd <= 1'b1;
    event_raise <= 1'b1;
    @(posedge core_clk);
    event_raise <= 1'b0;
    tick(1);
    chk(state_a, exp_a(16'h3617, 1'b1, 1'b1));
    i_ctrl.send_pair(16'h3617, 16'h3617);
    tick(3);
    chk({15'h0, ack_pulse}, 16'h0000);
    chk(state_a, exp_a(16'h3617, 1'b1, 1'b1));
    i_ctrl.send_pair(16'h3697, 16'h3617);
    for (int k = 0; k < 3; k++) begin
      tick(1);
      chk({15'h0, ack_pulse}, {15'h0, k == 0});
    end
    chk(state_a, exp_a(16'h3617, 1'b1, 1'b0));
    // safety inputs: every level, use and disable combination
    for (int k = 0; k < 512; k++) begin
      @(posedge core_clk);
      safe_in <= k[8:0];
      tick(1);
      chk(state_in, {5'h00, k[8:6] & k[5:3] & ~k[2:0], 8'h00});
    end
    end_sim();
  end
endmodule
`default_nettype wire

/* dv/safety_controller_model.sv */
// partner model: higher-level controller that sends the command words
// assumes the block loads both words on a rising edge while cmd_valid is high
`timescale 1ns/1ps
`default_nettype none
module safety_controller_model (
  input  wire logic        core_clk,
  output logic             cmd_valid,
  output logic [15:0]      cmd_a,
  output logic [15:0]      cmd_b
);
  initial begin
    cmd_valid = 1'b0;
    cmd_a     = 16'h3617;
    cmd_b     = 16'h0000;
  end
  // =====
  // two back-to-back loads; an ack is bit 7 high in w1, low in w2
  // the released cmd_a line shows the inverse so a stale value cannot pass; cmd_b is never driven and stays zero
  task automatic send_pair(input logic [15:0] w1, input logic [15:0] w2);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_a     <= w1;
    @(posedge core_clk);
    cmd_a     <= w2;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_a     <= ~w2;
  endtask
endmodule
`default_nettype wire

/* verilog/safety_control_status_words.sv */
// decodes safety command words and builds safety state words
// assumes command words arrive synchronously, both words loaded on every edge that cmd_valid and clk_en are high
`timescale 1ns/1ps
`default_nettype none
`include "safety_words_defines.svh"

module safety_control_status_words
  import safety_words_pkg::*;
(
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  input  wire logic                         cmd_valid,
  input  wire logic [15:0]                  safety_command_word_a,
  input  wire logic [15:0]                  safety_command_word_b,
  input  wire logic                         event_raise,
  input  wire logic                         speed_below_limit,
  input  wire safety_words_pkg::safe_inputs_t safe_inputs,
  output logic [15:0]                       safety_state_word_a,
  output logic [15:0]                       safety_input_state_word,
  output logic                              event_ack_pulse,
  output safety_words_pkg::func_sel_t       func_active
);
  import safety_words_pkg::*;

  // ==========================================================
  // command capture
  logic [15:0] cmd_a_ff;
  logic [15:0] cmd_b_ff;
  logic        ack_prev_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_a_ff <= `CMD_A_RESET;
      cmd_b_ff <= `WORD_ZERO;
    end else if (clk_en && cmd_valid) begin
      cmd_a_ff <= safety_command_word_a;
      cmd_b_ff <= safety_command_word_b;
    end
  end

  // ==========================================================
  // function decode; unlisted command bits are never looked at
  func_sel_t nxt_func;
  assign nxt_func.torque_off      = ~cmd_a_ff[`CMD_TORQUE_OFF_BIT];
  assign nxt_func.controlled_stop = ~cmd_a_ff[`CMD_STOP_BIT];
  assign nxt_func.limited_speed   = ~cmd_a_ff[`CMD_LIMSPEED_BIT];
  assign nxt_func.speed_level     = {cmd_a_ff[`CMD_LEVEL_HI_BIT], cmd_a_ff[`CMD_LEVEL_LO_BIT]};
  assign nxt_func.dir_pos         = ~cmd_a_ff[`CMD_DIR_POS_BIT];
  assign nxt_func.dir_neg         = ~cmd_a_ff[`CMD_DIR_NEG_BIT];

  // ==========================================================
  // acknowledge edge and event flag
  // a steady zero must not ack, so only the falling edge counts
  wire ack_fall = ack_prev_ff & ~cmd_a_ff[`CMD_EVENT_ACK_BIT];
  logic event_ff;
  logic ack_pulse_ff;
  // a new event in the ack cycle keeps the flag set
  wire  nxt_event = event_raise | (event_ff & ~ack_fall);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_prev_ff  <= 1'b0;
      event_ff     <= 1'b0;
      ack_pulse_ff <= 1'b0;
      func_active  <= '0;
    end else if (clk_en) begin
      ack_prev_ff  <= cmd_a_ff[`CMD_EVENT_ACK_BIT];
      event_ff     <= nxt_event;
      ack_pulse_ff <= ack_fall;
      func_active  <= nxt_func;
    end
  end
  assign event_ack_pulse = ack_pulse_ff;

  // ==========================================================
  // state word a
  logic [15:0] nxt_state_a;
  always_comb begin
    nxt_state_a = `WORD_ZERO;
    nxt_state_a[`STA_TORQUE_OFF_BIT] = nxt_func.torque_off;
    nxt_state_a[`STA_STOP_BIT]       = nxt_func.controlled_stop;
    nxt_state_a[`STA_LIMSPEED_BIT]   = nxt_func.limited_speed;
    nxt_state_a[`STA_EVENT_BIT]      = nxt_event;
    nxt_state_a[`STA_LEVEL_LO_BIT]   = nxt_func.speed_level[0];
    nxt_state_a[`STA_LEVEL_HI_BIT]   = nxt_func.speed_level[1];
    nxt_state_a[`STA_DIR_POS_BIT]    = nxt_func.dir_pos;
    nxt_state_a[`STA_DIR_NEG_BIT]    = nxt_func.dir_neg;
    nxt_state_a[`STA_SPEED_MON_BIT]  = speed_below_limit;
  end

  // ==========================================================
  // input state word
  logic [15:0] nxt_input_state;
  logic [2:0]  input_gated;
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_SAFE_INPUTS; gi++) begin : g_in
      // unused or discrepancy-disabled inputs read zero regardless of level
      assign input_gated[gi] = safe_inputs.level[gi] & safe_inputs.in_use[gi]
                             & ~safe_inputs.disabled[gi];
    end
  endgenerate
  always_comb begin
    nxt_input_state = `WORD_ZERO;
    nxt_input_state[`INPUT_STATE_LSB +: `NUM_SAFE_INPUTS] = input_gated;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      safety_state_word_a     <= `WORD_ZERO;
      safety_input_state_word <= `WORD_ZERO;
    end else if (clk_en) begin
      safety_state_word_a     <= nxt_state_a;
      safety_input_state_word <= nxt_input_state;
    end
  end

  // ==========================================================
  // checks: command decode
  // the first edge after reset still shows the reset word, so mappings wait one edge
  a_torque_select_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> safety_state_word_a[0] == ~$past(cmd_a_ff[0]))
    else $error("torque off status does not follow select");

  a_stop_select_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> safety_state_word_a[1] == ~$past(cmd_a_ff[1]))
    else $error("controlled stop status does not follow select");

  a_limspeed_select_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> safety_state_word_a[4] == ~$past(cmd_a_ff[4]))
    else $error("limited speed status does not follow select");

  a_level_echo: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> safety_state_word_a[10:9] == {$past(cmd_a_ff[10]), $past(cmd_a_ff[9])})
    else $error("speed level not echoed");

  a_dir_pos_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> safety_state_word_a[12] == ~$past(cmd_a_ff[12]))
    else $error("positive direction status wrong");

  a_dir_neg_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> safety_state_word_a[13] == ~$past(cmd_a_ff[13]))
    else $error("negative direction status wrong");

  a_speed_mon_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> safety_state_word_a[15] == $past(speed_below_limit))
    else $error("speed monitor bit wrong");

  a_func_torque_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> func_active.torque_off == ~$past(cmd_a_ff[0]))
    else $error("torque off function flag wrong");

  a_func_stop_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> func_active.controlled_stop == ~$past(cmd_a_ff[1]))
    else $error("controlled stop function flag wrong");

  a_func_limspeed_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> func_active.limited_speed == ~$past(cmd_a_ff[4]))
    else $error("limited speed function flag wrong");

  a_func_level_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> func_active.speed_level == $past(cmd_a_ff[10:9]))
    else $error("speed level function field wrong");

  a_func_dir_pos: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> func_active.dir_pos == ~$past(cmd_a_ff[12]))
    else $error("positive direction function flag wrong");

  a_func_dir_neg: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n) |-> func_active.dir_neg == ~$past(cmd_a_ff[13]))
    else $error("negative direction function flag wrong");

  a_torque_agree: assert property (@(posedge core_clk) disable iff (!rst_n)
    func_active.torque_off == safety_state_word_a[0])
    else $error("torque off flag and state bit differ");

  a_stop_agree: assert property (@(posedge core_clk) disable iff (!rst_n)
    func_active.controlled_stop == safety_state_word_a[1])
    else $error("controlled stop flag and state bit differ");

  a_limspeed_agree: assert property (@(posedge core_clk) disable iff (!rst_n)
    func_active.limited_speed == safety_state_word_a[4])
    else $error("limited speed flag and state bit differ");

  a_level_agree: assert property (@(posedge core_clk) disable iff (!rst_n)
    func_active.speed_level == safety_state_word_a[10:9])
    else $error("speed level field and state bits differ");

  a_dir_pos_agree: assert property (@(posedge core_clk) disable iff (!rst_n)
    func_active.dir_pos == safety_state_word_a[12])
    else $error("positive direction flag and state bit differ");

  a_dir_neg_agree: assert property (@(posedge core_clk) disable iff (!rst_n)
    func_active.dir_neg == safety_state_word_a[13])
    else $error("negative direction flag and state bit differ");

  // ==========================================================
  // checks: event and acknowledge
  a_ack_falling_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && event_ff && !event_raise && !ack_fall |=> event_ff)
    else $error("event flag cleared without falling ack");

  a_ack_clears_event: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && ack_fall && !event_raise |=> !event_ff && event_ack_pulse)
    else $error("falling ack did not clear event");

  a_ack_needs_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !ack_fall |=> !event_ack_pulse)
    else $error("ack pulse without falling ack");

  a_steady_zero_no_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !ack_prev_ff |=> !event_ack_pulse)
    else $error("steady zero produced an ack pulse");

  a_ack_pulse_on_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && ack_fall |=> event_ack_pulse)
    else $error("falling ack gave no pulse");

  a_event_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && event_raise |=> event_ff && safety_state_word_a[7])
    else $error("internal event not signalled");

  a_event_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && event_raise && ack_fall |=> event_ff)
    else $error("ack in event cycle lost the event");

  a_event_bit_tracks: assert property (@(posedge core_clk) disable iff (!rst_n)
    safety_state_word_a[7] == event_ff)
    else $error("event state bit and flag differ");

  a_idle_no_event: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !event_ff && !event_raise |=> !safety_state_word_a[7])
    else $error("event bit set in fault-free operation");

  // ==========================================================
  // checks: input state word
  a_unused_input_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !safe_inputs.in_use[0] |=> !safety_input_state_word[8])
    else $error("unused input reads nonzero");

  a_unused_input1_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !safe_inputs.in_use[1] |=> !safety_input_state_word[9])
    else $error("unused input 1 reads nonzero");

  a_unused_input2_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !safe_inputs.in_use[2] |=> !safety_input_state_word[10])
    else $error("unused input 2 reads nonzero");

  a_disabled_input_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && safe_inputs.disabled[1] |=> !safety_input_state_word[9])
    else $error("disabled input reads nonzero");

  a_disabled_input0_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && safe_inputs.disabled[0] |=> !safety_input_state_word[8])
    else $error("disabled input 0 reads nonzero");

  a_disabled_input2_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && safe_inputs.disabled[2] |=> !safety_input_state_word[10])
    else $error("disabled input 2 reads nonzero");

  a_input_level_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && safe_inputs.in_use[2] && !safe_inputs.disabled[2]
    |=> safety_input_state_word[10] == $past(safe_inputs.level[2]))
    else $error("input level not passed");

  a_input0_level_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && safe_inputs.in_use[0] && !safe_inputs.disabled[0]
    |=> safety_input_state_word[8] == $past(safe_inputs.level[0]))
    else $error("input 0 level not passed");

  a_input1_level_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && safe_inputs.in_use[1] && !safe_inputs.disabled[1]
    |=> safety_input_state_word[9] == $past(safe_inputs.level[1]))
    else $error("input 1 level not passed");

  // ==========================================================
  // checks: freeze and reserved bits
  a_freeze_state_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !clk_en |=> $stable(safety_state_word_a))
    else $error("state word a moved while frozen");

  a_freeze_input_word: assert property (@(posedge core_clk) disable iff (!rst_n)
    !clk_en |=> $stable(safety_input_state_word))
    else $error("input state word moved while frozen");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    safety_input_state_word[7:0] == 8'h00 && safety_input_state_word[15:11] == 5'h00
    && safety_state_word_a[3:2] == 2'h0 && safety_state_word_a[14] == 1'b0)
    else $error("reserved state bits nonzero");

  a_reserved_gap_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    safety_state_word_a[6:5] == 2'h0 && safety_state_word_a[8] == 1'b0 && safety_state_word_a[11] == 1'b0)
    else $error("not relevant state bits nonzero");

endmodule
`default_nettype wire
